// ---- sfi_cmd_core.sv ----
// serial flash instruction core: wrap setup, id reads, power-down, security reads
// assumes link pins arrive unsynchronised; status, reset and security data are
// on core_clk, security data valid one cycle after the address it answers
//
// Behaviour
// - wrap setup is 77h, 24 dummy bits, 8 wrap bits, then select high
// - stored wrap setting is offered to quad io and quad word reads
// - wrap disable bit powers up 1; writing 1 again restores linear reads
// - length bits pick 8, 16, 32 or 64 byte sections when enabled
// - 90h with address 0 gives maker first, address 1 gives device first
// - 92h is the same read with two bits per clock
// - 94h moves four bits per clock with four dummy clocks after address
// - 9fh returns maker, memory type, capacity on falling edges
// - 9fh is not decoded while a program or erase runs
// - select high during output aborts it and returns to standby
// - 4bh plus four dummy bytes shifts out the 64 bit unique number
// - b9h acts only if select rises after bit eight; entry within delay
// - powered down, every instruction except release is ignored
// - the device starts in normal standby, not powered down
// - abh alone releases power-down after the plain release delay
// - abh plus three dummy bytes repeats the device code msb first
// - abh while write in progress is ignored
// - 48h takes address and dummy byte, then bytes with rising address
// - address bits 15:12 pick register 1 to 3; byte index wraps ff to 00
// - software reset restores the wrap field to its power-on value
`timescale 1ns/1ns
module sfi_cmd_core import sfi_pkg::*; #(
	parameter logic [7:0]  MAKER_CODE  = 8'h5a,                 // arbitrary value
	parameter logic [7:0]  DEVICE_CODE = 8'h17,                 // arbitrary value
	parameter logic [7:0]  MEM_TYPE    = 8'h40,                 // arbitrary value
	parameter logic [7:0]  CAPACITY    = 8'h18,                 // arbitrary value
	parameter logic [63:0] UNIQUE_ID   = 64'h0123_4567_89ab_cdef // arbitrary value
) (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// serial link pins
	input  wire logic        cs_n,
	input  wire logic        sclk,
	input  wire logic [3:0]  io_in,
	output logic      [3:0]  io_out_q,
	output logic      [3:0]  io_oe_q,
	// device status and software reset
	input  wire logic        write_in_progress_flag,
	input  wire logic        soft_reset,
	// wrap setting for the quad read path
	output logic      [2:0]  wrap_field_q,
	output logic      [5:0]  wrap_mask_q,
	// power state
	output logic             deep_power_down_state_q,
	output logic             pd_busy_q,
	// security register read port
	output logic             sec_rd_en_q,
	output logic      [9:0]  sec_rd_addr_q,
	input  wire logic [7:0]  sec_rd_data
);

	localparam int A_PD_CYC   = int'(PD_ENTRY_CYC);
	localparam int A_REL1_MAX = int'(RELEASE_PLAIN_CYC) + 1;

	// section mask from the two length bits
	function automatic logic [5:0] wrap_mask(input logic [1:0] len);
		unique case (len)
			2'b00: wrap_mask = 6'h07;
			2'b01: wrap_mask = 6'h0f;
			2'b10: wrap_mask = 6'h1f;
			2'b11: wrap_mask = 6'h3f;
		endcase
	endfunction : wrap_mask

	sfi_state_t   st_q;
	logic [6:0]   meta_q;
	logic [6:0]   sync_q;
	logic [1:0]   prev_q;
	logic [7:0]   op_q;
	logic [2:0]   wid_q;
	logic [5:0]   cnt_q;
	logic [5:0]   dum_q;
	logic [31:0]  sr_q;
	logic [23:0]  addr_q;
	logic [7:0]   tmr_q;
	logic         entering_q;
	logic [7:0]   idx_q;
	logic [3:0]   bit_q;

	logic         cs_s;
	logic         rise;
	logic         fall;
	logic         cs_up;
	logic         cs_dn;
	logic [31:0]  sr_in;
	logic [5:0]   cnt_nx;
	logic [3:0]   bit_nx;
	logic         lockout;
	logic         wrap_commit;
	logic         dpd_commit;
	logic         res_commit;
	logic         sec_valid;
	logic [7:0]   cur_byte;
	logic [7:0]   cur_sh;
	logic [63:0]  uid_sh;

	// two flops on every pin; only the second stage and later are read
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 7'h7f;
			sync_q <= 7'h7f;
			prev_q <= 2'h3;
		end else begin
			meta_q <= {cs_n, sclk, 1'b0, io_in};
			sync_q <= meta_q;
			prev_q <= sync_q[6:5];
		end
	end

	// link edges, seen only while selected
	assign cs_s  = sync_q[6];
	assign rise  = sync_q[5] & ~prev_q[0] & ~cs_s;
	assign fall  = ~sync_q[5] & prev_q[0] & ~cs_s;
	assign cs_up = cs_s & ~prev_q[1];
	assign cs_dn = ~cs_s & prev_q[1];

	// shift in at the current lane width
	always_comb begin
		unique case (wid_q)
			WID_DUAL: sr_in = {sr_q[29:0], sync_q[1:0]};
			WID_QUAD: sr_in = {sr_q[27:0], sync_q[3:0]};
			default:  sr_in = {sr_q[30:0], sync_q[0]};
		endcase
	end
	assign cnt_nx = cnt_q + {3'h0, wid_q};

	// a timer running, or power-down for all but abh, blocks decode; busy blocks abh and 9fh
	assign lockout = (tmr_q != 8'h00) ||
		(deep_power_down_state_q && sr_in[7:0] != OP_RES) ||
		(write_in_progress_flag && sr_in[7:0] == OP_JID) ||
		(write_in_progress_flag && sr_in[7:0] == OP_RES);

	// command sequencer, stepped on rising link edges
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q   <= ST_IDLE;
			op_q   <= 8'h00;
			wid_q  <= WID_SINGLE;
			cnt_q  <= 6'h00;
			dum_q  <= 6'h00;
			sr_q   <= 32'h0000_0000;
			addr_q <= 24'h00_0000;
		end else if (cs_up || soft_reset) begin
			st_q <= ST_IDLE;
		end else if (cs_dn) begin
			st_q  <= ST_CMD;
			wid_q <= WID_SINGLE;
			cnt_q <= 6'h00;
		end else if (rise) begin
			sr_q  <= sr_in;
			cnt_q <= cnt_nx;
			unique case (st_q)
				ST_CMD: begin
					if (cnt_nx == CMD_BITS) begin
						op_q  <= sr_in[7:0];
						cnt_q <= 6'h00;
						if (lockout) begin
							st_q <= ST_HOLD;
						end else begin
							unique case (sr_in[7:0])
								OP_WRAP, OP_MID, OP_SEC: st_q <= ST_ADDR;
								OP_MID2: begin
									st_q  <= ST_ADDR;
									wid_q <= WID_DUAL;
								end
								OP_MID4: begin
									st_q  <= ST_ADDR;
									wid_q <= WID_QUAD;
								end
								OP_JID: st_q <= ST_OUT;
								OP_UID: begin
									st_q  <= ST_DUMMY;
									dum_q <= DUM_UID;
								end
								OP_DPD, OP_RES: st_q <= ST_END;
								default: st_q <= ST_HOLD;
							endcase
						end
					end
				end
				ST_ADDR: begin
					if (cnt_nx == ADDR_BITS) begin
						addr_q <= sr_in[23:0];
						cnt_q  <= 6'h00;
						if (op_q == OP_WRAP) begin
							st_q <= ST_WRAP;
						end else if (op_q == OP_MID4) begin
							st_q  <= ST_DUMMY;
							dum_q <= DUM_QUAD_ID;
						end else if (op_q == OP_SEC) begin
							st_q  <= ST_DUMMY;
							dum_q <= DUM_SEC;
						end else begin
							st_q <= ST_OUT;
						end
					end
				end
				ST_DUMMY: begin
					if (cnt_nx == dum_q) begin
						st_q <= ST_OUT;
					end
				end
				ST_WRAP: begin
					if (cnt_nx == WRAP_BITS) begin
						st_q <= ST_END;
					end
				end
				ST_END: begin
					// a clock after bit eight cancels power-down entry
					if (op_q == OP_RES) begin
						st_q  <= ST_DUMMY;
						dum_q <= DUM_RES;
					end else begin
						st_q <= ST_HOLD;
					end
				end
				ST_IDLE, ST_OUT, ST_HOLD: st_q <= st_q;
			endcase
		end
	end

	// actions taken when select rises at a legal point
	assign wrap_commit = cs_up && st_q == ST_END && op_q == OP_WRAP;
	assign dpd_commit  = cs_up && st_q == ST_END && op_q == OP_DPD;
	assign res_commit  = cs_up && op_q == OP_RES && deep_power_down_state_q &&
		(st_q == ST_END || st_q == ST_DUMMY || st_q == ST_OUT);

	// wrap field and the section mask the quad read path applies
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wrap_field_q <= WRAP_DEFAULT;
			wrap_mask_q  <= WRAP_MASK_OFF;
		end else if (soft_reset) begin
			wrap_field_q <= WRAP_DEFAULT;
			wrap_mask_q  <= WRAP_MASK_OFF;
		end else if (wrap_commit) begin
			wrap_field_q <= sr_q[6:4];
			wrap_mask_q  <= sr_q[WRAP_DIS_POS] ? WRAP_MASK_OFF : wrap_mask(sr_q[6:5]);
		end
	end

	// power-down entry and release timing; commands are ignored while it runs
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			deep_power_down_state_q <= 1'b0;
			pd_busy_q  <= 1'b0;
			tmr_q      <= 8'h00;
			entering_q <= 1'b0;
		end else if (soft_reset) begin
			deep_power_down_state_q <= 1'b0;
			pd_busy_q  <= 1'b0;
			tmr_q      <= 8'h00;
			entering_q <= 1'b0;
		end else if (dpd_commit) begin
			tmr_q      <= PD_ENTRY_CYC;
			pd_busy_q  <= 1'b1;
			entering_q <= 1'b1;
		end else if (res_commit) begin
			// the code read variant uses its own release wait, the same length as the plain one
			tmr_q      <= (st_q == ST_END) ? RELEASE_PLAIN_CYC : RELEASE_CODE_CYC;
			pd_busy_q  <= 1'b1;
			entering_q <= 1'b0;
		end else if (tmr_q != 8'h00) begin
			tmr_q <= tmr_q - 8'h01;
			if (tmr_q == 8'h01) begin
				deep_power_down_state_q <= entering_q;
				pd_busy_q <= 1'b0;
			end
		end
	end

	// security register select must be 1 to 3 with zero upper fields
	assign sec_valid = addr_q[23:16] == SEC_HIGH_ZERO && addr_q[11:8] == SEC_MID_ZERO &&
		addr_q[15:12] != 4'h0 && addr_q[15:14] == 2'b00;
	assign uid_sh = UNIQUE_ID << {idx_q[2:0], 3'h0};

	// byte currently on the wire
	always_comb begin
		unique case (op_q)
			OP_MID, OP_MID2, OP_MID4:
				cur_byte = (idx_q[0] ^ addr_q[0]) ? DEVICE_CODE : MAKER_CODE;
			OP_JID:
				cur_byte = (idx_q == 8'h00) ? MAKER_CODE :
					((idx_q == 8'h01) ? MEM_TYPE : CAPACITY);
			OP_UID:  cur_byte = uid_sh[63:56];
			OP_RES:  cur_byte = DEVICE_CODE;
			OP_SEC:  cur_byte = sec_valid ? sec_rd_data : 8'h00;
			default: cur_byte = 8'h00;
		endcase
	end
	assign cur_sh = cur_byte << bit_q;
	assign bit_nx = bit_q + {1'b0, wid_q};

	// output shifter, driven on falling link edges, msb first
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			io_out_q <= 4'h0;
			io_oe_q  <= 4'h0;
			idx_q    <= 8'h00;
			bit_q    <= 4'h0;
		end else if (st_q != ST_OUT || cs_up) begin
			io_oe_q <= 4'h0;
			idx_q   <= 8'h00;
			bit_q   <= 4'h0;
		end else if (fall) begin
			unique case (wid_q)
				WID_QUAD: begin
					io_out_q <= cur_sh[7:4];
					io_oe_q  <= 4'hf;
				end
				WID_DUAL: begin
					io_out_q <= {2'h0, cur_sh[7:6]};
					io_oe_q  <= 4'h3;
				end
				default: begin
					io_out_q <= {2'h0, cur_sh[7], 1'b0};
					io_oe_q  <= 4'h2;
				end
			endcase
			if (bit_nx == BYTE_BITS) begin
				bit_q <= 4'h0;
				// 9fh cycles its three bytes; others roll the 8-bit index
				idx_q <= (op_q == OP_JID && idx_q == JID_LAST_IDX) ? 8'h00 : idx_q + 8'h01;
			end else begin
				bit_q <= bit_nx;
			end
		end
	end

	// security read address; byte index wraps inside the chosen register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sec_rd_en_q   <= 1'b0;
			sec_rd_addr_q <= 10'h000;
		end else begin
			sec_rd_en_q   <= st_q == ST_OUT && op_q == OP_SEC && sec_valid;
			sec_rd_addr_q <= {addr_q[13:12], addr_q[7:0] + idx_q};
		end
	end

	a_wrap_mask_len: assert property (@(posedge core_clk) disable iff (!rst_n)
		!wrap_field_q[0] |-> wrap_mask_q == wrap_mask(wrap_field_q[2:1]))
		else $error("wrap mask does not match length bits");

	a_wrap_soft_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
		soft_reset |=> wrap_field_q == WRAP_DEFAULT && wrap_mask_q == WRAP_MASK_OFF)
		else $error("soft reset left wrap setting");

	a_pd_entry_time: assert property (@(posedge core_clk) disable iff (!rst_n)
		dpd_commit && !soft_reset |=> !deep_power_down_state_q ##A_PD_CYC deep_power_down_state_q)
		else $error("power-down not entered on time");

	a_pd_ignore_cmd: assert property (@(posedge core_clk) disable iff (!rst_n)
		st_q == ST_CMD && rise && cnt_nx == CMD_BITS && deep_power_down_state_q &&
		sr_in[7:0] != OP_RES && !cs_up && !soft_reset |=> st_q == ST_HOLD)
		else $error("instruction decoded while powered down");

	a_release_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
		res_commit && st_q == ST_END && !soft_reset |-> ##[1:A_REL1_MAX] !deep_power_down_state_q)
		else $error("release from power-down late");

	a_jid_busy: assert property (@(posedge core_clk) disable iff (!rst_n)
		st_q == ST_CMD && rise && cnt_nx == CMD_BITS && sr_in[7:0] == OP_JID &&
		write_in_progress_flag && !cs_up && !soft_reset |=> st_q == ST_HOLD)
		else $error("id read decoded during busy");

	a_res_busy: assert property (@(posedge core_clk) disable iff (!rst_n)
		st_q == ST_CMD && rise && cnt_nx == CMD_BITS && sr_in[7:0] == OP_RES &&
		write_in_progress_flag && !cs_up && !soft_reset |=> st_q == ST_HOLD ##1 !pd_busy_q)
		else $error("release instruction taken during busy");

	a_cs_abort: assert property (@(posedge core_clk) disable iff (!rst_n)
		cs_up |=> io_oe_q == 4'h0 ##1 st_q == ST_IDLE || st_q == ST_CMD)
		else $error("output not released on select high");

	a_id_first: assert property (@(posedge core_clk) disable iff (!rst_n)
		st_q == ST_OUT && op_q == OP_MID && idx_q == 8'h00 |->
		cur_byte == (addr_q[0] ? DEVICE_CODE : MAKER_CODE))
		else $error("wrong first id byte");

	a_sec_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
		st_q == ST_OUT && op_q == OP_SEC && fall && !cs_up && bit_nx == BYTE_BITS &&
		addr_q[7:0] + idx_q == 8'hff |=> ##1 sec_rd_addr_q[7:0] == 8'h00)
		else $error("security byte index did not wrap");

endmodule : sfi_cmd_core

// ---- sfi_pkg.sv ----
// constants shared by the serial flash id / power / wrap command core
// assumes a 10 MHz core clock and a host link clock far slower than it
package sfi_pkg;

	// opcodes decoded by the core
	localparam logic [7:0] OP_WRAP = 8'h77;
	localparam logic [7:0] OP_MID  = 8'h90;
	localparam logic [7:0] OP_MID2 = 8'h92;
	localparam logic [7:0] OP_MID4 = 8'h94;
	localparam logic [7:0] OP_JID  = 8'h9f;
	localparam logic [7:0] OP_UID  = 8'h4b;
	localparam logic [7:0] OP_DPD  = 8'hb9;
	localparam logic [7:0] OP_RES  = 8'hab;
	localparam logic [7:0] OP_SEC  = 8'h48;

	// bits moved per link clock
	localparam logic [2:0] WID_SINGLE = 3'h1;
	localparam logic [2:0] WID_DUAL   = 3'h2;
	localparam logic [2:0] WID_QUAD   = 3'h4;

	// phase lengths in bits
	localparam logic [5:0] CMD_BITS      = 6'h08;
	localparam logic [5:0] ADDR_BITS     = 6'h18;
	localparam logic [5:0] WRAP_BITS     = 6'h08;
	localparam logic [5:0] DUM_QUAD_ID   = 6'h10;
	localparam logic [5:0] DUM_SEC       = 6'h08;
	localparam logic [5:0] DUM_UID       = 6'h20;
	localparam logic [5:0] DUM_RES       = 6'h18;
	localparam logic [3:0] BYTE_BITS     = 4'h8;
	localparam logic [7:0] JID_LAST_IDX  = 8'h02;

	// wrap field: bit 0 disables wrap, bits 2:1 give the length
	localparam logic [2:0] WRAP_DEFAULT  = 3'h1;
	localparam int         WRAP_DIS_POS  = 4;
	localparam logic [5:0] WRAP_MASK_OFF = 6'h00;

	// security register address fields
	localparam logic [7:0] SEC_HIGH_ZERO = 8'h00;
	localparam logic [3:0] SEC_MID_ZERO  = 4'h0;

	// timing
	localparam int CLK_PERIOD_NS    = 100;
	localparam int PD_ENTRY_NS      = 3000;
	localparam int RELEASE_PLAIN_NS = 3000;
	localparam int RELEASE_CODE_NS  = 3000;
	localparam logic [7:0] PD_ENTRY_CYC      = 8'(PD_ENTRY_NS / CLK_PERIOD_NS);
	localparam logic [7:0] RELEASE_PLAIN_CYC = 8'(RELEASE_PLAIN_NS / CLK_PERIOD_NS);
	localparam logic [7:0] RELEASE_CODE_CYC  = 8'(RELEASE_CODE_NS / CLK_PERIOD_NS);

	// command sequencer states
	typedef enum logic [2:0] {
		ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_WRAP, ST_END, ST_OUT, ST_HOLD
	} sfi_state_t;

endpackage : sfi_pkg

// ---- sfi_host_model.sv ----
// host side of the serial flash link: select, link clock and data lines
// assumes core_clk paces the link; 8 core cycles make one link clock
`timescale 1ns/1ns
module sfi_host_model (
	// core clock pacing the link
	input  wire logic       core_clk,
	// device side of the data lines
	input  wire logic [3:0] io_out_q,
	input  wire logic [3:0] io_oe_q,
	// link pins driven by the host
	output logic            cs_n,
	output logic            sclk,
	output logic      [3:0] io_in,
	// set once the device drove any line in this frame
	output logic            oe_seen
);
	logic [3:0] drv;

	// link idles with select high and clock high, standing still between frames
	initial begin
		cs_n = 1'b1;
		sclk = 1'b1;
		drv = 4'h0;
		oe_seen = 1'b0;
	end

	// wire level: the device wins on every line it enables
	assign io_in = (io_oe_q & io_out_q) | (~io_oe_q & drv);

	// remembers any drive by the device while selected
	always @(posedge core_clk) begin
		if (!cs_n && (|io_oe_q))
			oe_seen <= 1'b1;
	end

	task automatic start();
		cs_n <= 1'b0;
		oe_seen <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask : start

	// select rises right after the last clock; idle lines flip so no stale level survives
	task automatic stop();
		cs_n <= 1'b1;
		drv <= ~drv;
		repeat (8) @(posedge core_clk);
	endtask : stop

	// n bits at w bits per clock, msb first; data set on the fall, sampled mid high phase
	task automatic xfer(input logic [2:0] w, input int n, input logic [63:0] din,
		output logic [63:0] dout);
		logic [3:0] d;
		logic [3:0] q;
		dout = 64'h0;
		for (int i = 0; i < n / int'(w); i++) begin
			d = ~drv; // lines not carrying data toggle every clock
			case (w)
			3'h1: d[0] = din[63];
			3'h2: d[1:0] = din[63:62];
			default: d = din[63:60];
			endcase
			din = din << w;
			sclk <= 1'b0;
			drv <= d;
			repeat (4) @(posedge core_clk);
			sclk <= 1'b1;
			repeat (2) @(posedge core_clk);
			q = io_in;
			case (w)
			3'h1: dout = {dout[62:0], q[1]};
			3'h2: dout = {dout[61:0], q[1:0]};
			default: dout = {dout[59:0], q};
			endcase
			repeat (2) @(posedge core_clk);
		end
	endtask : xfer

endmodule : sfi_host_model

// ---- tb_top.sv ----
// self-checking bench for the serial flash command core
// assumes the host model paces the link and a small table answers security reads
`timescale 1ns/1ns
module tb_top import sfi_pkg::*;;
	// id values given to the core; all arbitrary
	localparam logic [7:0]  MK  = 8'h3c;
	localparam logic [7:0]  DV  = 8'hd2;
	localparam logic [7:0]  MT  = 8'h61;
	localparam logic [7:0]  CP  = 8'h19;
	localparam logic [63:0] UID = 64'hfeed_0123_c0de_4567;

	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cs_n;
	logic        sclk;
	logic [3:0]  io_in;
	logic [3:0]  io_out_q;
	logic [3:0]  io_oe_q;
	logic        write_in_progress_flag = 1'b0;
	logic        soft_reset = 1'b0;
	logic [2:0]  wrap_field_q;
	logic [5:0]  wrap_mask_q;
	logic        deep_power_down_state_q;
	logic        pd_busy_q;
	logic        sec_rd_en_q;
	logic [9:0]  sec_rd_addr_q;
	logic [7:0]  sec_rd_data = 8'h00;
	logic        oe_seen;
	logic [63:0] got;
	int          fails = 0;
	int          checks_done = 0;

	always #50 core_clk = ~core_clk;

	sfi_cmd_core #(.MAKER_CODE(MK), .DEVICE_CODE(DV), .MEM_TYPE(MT), .CAPACITY(CP),
		.UNIQUE_ID(UID)) sfi_cmd_core_inst (
		.core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .io_in(io_in),
		.io_out_q(io_out_q), .io_oe_q(io_oe_q),
		.write_in_progress_flag(write_in_progress_flag), .soft_reset(soft_reset),
		.wrap_field_q(wrap_field_q), .wrap_mask_q(wrap_mask_q),
		.deep_power_down_state_q(deep_power_down_state_q), .pd_busy_q(pd_busy_q),
		.sec_rd_en_q(sec_rd_en_q), .sec_rd_addr_q(sec_rd_addr_q), .sec_rd_data(sec_rd_data));

	sfi_host_model sfi_host_model_inst (
		.core_clk(core_clk), .io_out_q(io_out_q), .io_oe_q(io_oe_q), .cs_n(cs_n),
		.sclk(sclk), .io_in(io_in), .oe_seen(oe_seen));

	// security contents derived from the address; data trails the address by one cycle
	function automatic logic [7:0] sec_byte(input logic [9:0] a);
		return a[7:0] ^ {6'h00, a[9:8]} ^ 8'h5e;
	endfunction : sec_byte

	always @(posedge core_clk) begin
		sec_rd_data <= sec_rd_en_q ? sec_byte(sec_rd_addr_q) : ~sec_rd_data;
	end

	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] seen);
		checks_done++;
		if (seen !== exp) begin
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
			fails++;
		end
	endtask : chk

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out

	task automatic cmd(input logic [7:0] op);
		sfi_host_model_inst.start();
		sfi_host_model_inst.xfer(3'h1, 8, {op, 56'h0}, got);
	endtask : cmd

	task automatic tx(input logic [2:0] w, input int n, input logic [63:0] d);
		sfi_host_model_inst.xfer(w, n, d, got);
	endtask : tx

	task automatic rd(input logic [2:0] w, input int n);
		sfi_host_model_inst.xfer(w, n, 64'h5555_5555_5555_5555, got);
	endtask : rd

	// bounded wait for the power state, then compare it
	task automatic wait_pd(input logic exp);
		for (int i = 0; i < 80 && deep_power_down_state_q !== exp; i++)
			@(posedge core_clk);
		chk("power_down", {63'h0, exp}, {63'h0, deep_power_down_state_q});
	endtask : wait_pd

	// wrap byte after 24 dummy bits; an extra clock before select rises spoils it
	task automatic wrap_set(input logic [7:0] wb, input bit extra);
		cmd(OP_WRAP);
		tx(3'h1, 32, {24'h0, wb, 32'h0});
		if (extra)
			rd(3'h1, 1);
		sfi_host_model_inst.stop();
	endtask : wrap_set

	task automatic chk_wrap(input logic [2:0] f, input logic [5:0] m);
		chk("wrap_field", {61'h0, f}, {61'h0, wrap_field_q});
		chk("wrap_mask", {58'h0, m}, {58'h0, wrap_mask_q});
	endtask : chk_wrap

	initial begin
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk_wrap(3'h1, 6'h00);
		chk("power_down", 64'h0, {63'h0, deep_power_down_state_q});
		$display("test reset done");

		for (int k = 0; k < 4; k++) begin
			wrap_set({1'b0, 2'(k), 5'h00}, 1'b0);
			chk_wrap({2'(k), 1'b0}, 6'((8 << k) - 1));
		end
		wrap_set(8'h70, 1'b0);
		chk_wrap(3'h7, 6'h00);
		wrap_set(8'h20, 1'b0);
		wrap_set(8'h00, 1'b1);
		chk_wrap(3'h2, 6'h0f);
		soft_reset <= 1'b1;
		@(posedge core_clk);
		soft_reset <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk_wrap(3'h1, 6'h00);
		$display("test wrap done");

		cmd(OP_JID);
		rd(3'h1, 4);
		sfi_host_model_inst.stop();
		chk("abort_oe", 64'h0, {60'h0, io_oe_q});
		cmd(OP_JID);
		rd(3'h1, 32);
		sfi_host_model_inst.stop();
		chk("jedec_id", {32'h0, MK, MT, CP, MK}, got);
		for (int a = 0; a < 2; a++) begin
			cmd(OP_MID);
			tx(3'h1, 24, {23'h0, 1'(a), 40'h0});
			rd(3'h1, 32);
			sfi_host_model_inst.stop();
			chk("id_single", a ? {32'h0, DV, MK, DV, MK} : {32'h0, MK, DV, MK, DV}, got);
		end
		cmd(OP_MID2);
		tx(3'h2, 24, {24'h00_0001, 40'h0});
		rd(3'h2, 16);
		sfi_host_model_inst.stop();
		chk("id_dual", {48'h0, DV, MK}, got);
		cmd(OP_MID4);
		tx(3'h4, 24, 64'h0);
		tx(3'h4, 16, 64'h0);
		rd(3'h4, 16);
		sfi_host_model_inst.stop();
		chk("id_quad", {48'h0, MK, DV}, got);
		cmd(OP_UID);
		tx(3'h1, 32, 64'h0);
		rd(3'h1, 64);
		sfi_host_model_inst.stop();
		chk("unique_id", UID, got);
		cmd(OP_RES);
		tx(3'h1, 24, 64'h0);
		rd(3'h1, 16);
		sfi_host_model_inst.stop();
		chk("device_id", {48'h0, DV, DV}, got);
		$display("test id done");

		cmd(OP_SEC);
		tx(3'h1, 32, {24'h00_30fe, 40'h0});
		rd(3'h1, 24);
		sfi_host_model_inst.stop();
		chk("security", {40'h0, sec_byte(10'h3fe), sec_byte(10'h3ff), sec_byte(10'h300)},
			got);
		// a register select outside 1 to 3 reads as zero bytes
		cmd(OP_SEC);
		tx(3'h1, 32, {24'h00_40fe, 40'h0});
		rd(3'h1, 8);
		sfi_host_model_inst.stop();
		chk("security_bad", 64'h0, got);
		$display("test security done");

		write_in_progress_flag <= 1'b1;
		cmd(OP_JID);
		rd(3'h1, 16);
		sfi_host_model_inst.stop();
		chk("busy_jedec_oe", 64'h0, {63'h0, oe_seen});
		cmd(OP_RES);
		tx(3'h1, 24, 64'h0);
		rd(3'h1, 16);
		sfi_host_model_inst.stop();
		chk("busy_res_oe", 64'h0, {63'h0, oe_seen});
		write_in_progress_flag <= 1'b0;
		$display("test busy done");

		cmd(OP_DPD);
		rd(3'h1, 1);
		sfi_host_model_inst.stop();
		repeat (45) @(posedge core_clk);
		chk("late_select", 64'h0, {63'h0, deep_power_down_state_q});
		cmd(OP_DPD);
		sfi_host_model_inst.stop();
		wait_pd(1'b1);
		cmd(OP_JID);
		rd(3'h1, 16);
		sfi_host_model_inst.stop();
		chk("asleep_oe", 64'h0, {63'h0, oe_seen});
		cmd(OP_RES);
		sfi_host_model_inst.stop();
		wait_pd(1'b0);
		repeat (35) @(posedge core_clk);
		cmd(OP_JID);
		rd(3'h1, 8);
		sfi_host_model_inst.stop();
		chk("awake_id", {56'h0, MK}, got);
		// sleep again, then wake with the code read and its wait, the same length as the plain one
		cmd(OP_DPD);
		sfi_host_model_inst.stop();
		chk("pd_busy_on", 64'h1, {63'h0, pd_busy_q});
		wait_pd(1'b1);
		chk("pd_busy_off", 64'h0, {63'h0, pd_busy_q});
		cmd(OP_RES);
		tx(3'h1, 24, 64'h0);
		rd(3'h1, 16);
		sfi_host_model_inst.stop();
		chk("wake_code", {48'h0, DV, DV}, got);
		wait_pd(1'b0);
		repeat (RELEASE_CODE_CYC) @(posedge core_clk);
		cmd(OP_JID);
		rd(3'h1, 8);
		sfi_host_model_inst.stop();
		chk("code_wake_id", {56'h0, MK}, got);
		$display("test power done");
		close_out();
	end

	// hang guard far beyond the whole sequence
	initial begin
		repeat (60000) @(posedge core_clk);
		fails++;
		close_out();
	end

endmodule : tb_top
